// ===== rtl/swio_pkg.sv
// Purpose: constants for the single-wire byte write/read engine
// Assumes: 40 MHz clock, 32-bit AXI4-Lite register port
// Notes: slot phase times are plain defaults, adjust per line load
package swio_pkg;
  localparam int T_CLK_NS = 25;
  // latest start of line activity after a command, 262.5 ns
  localparam int T_START_MAX_PS = 262500;
  localparam int START_MAX_CYC = T_START_MAX_PS / (T_CLK_NS * 1000);
  // slot phase times, standard and overdrive
  localparam int T_SLOT_STD_NS = 70000;
  localparam int T_SLOT_OD_NS = 10000;
  localparam int T_LOW0_STD_NS = 60000;
  localparam int T_LOW0_OD_NS = 8000;
  localparam int T_LOW1_STD_NS = 6000;
  localparam int T_LOW1_OD_NS = 1000;
  localparam int T_SAMP_STD_NS = 15000;
  localparam int T_SAMP_OD_NS = 2000;
  localparam int T_APU_NS = 2500;
  localparam logic [11:0] SLOT_STD_CYC = 12'((T_SLOT_STD_NS + T_CLK_NS - 1) / T_CLK_NS);
  localparam logic [11:0] SLOT_OD_CYC = 12'((T_SLOT_OD_NS + T_CLK_NS - 1) / T_CLK_NS);
  localparam logic [11:0] LOW0_STD_CYC = 12'((T_LOW0_STD_NS + T_CLK_NS - 1) / T_CLK_NS);
  localparam logic [11:0] LOW0_OD_CYC = 12'((T_LOW0_OD_NS + T_CLK_NS - 1) / T_CLK_NS);
  localparam logic [11:0] LOW1_STD_CYC = 12'((T_LOW1_STD_NS + T_CLK_NS - 1) / T_CLK_NS);
  localparam logic [11:0] LOW1_OD_CYC = 12'((T_LOW1_OD_NS + T_CLK_NS - 1) / T_CLK_NS);
  localparam logic [11:0] SAMP_STD_CYC = 12'(T_SAMP_STD_NS / T_CLK_NS);
  localparam logic [11:0] SAMP_OD_CYC = 12'(T_SAMP_OD_NS / T_CLK_NS);
  localparam logic [11:0] APU_CYC = 12'((T_APU_NS + T_CLK_NS - 1) / T_CLK_NS);
  localparam logic [11:0] CNT_ONE = 12'h001;
  localparam logic [15:0] SLOTS_PER_BYTE = 16'h0008;
  localparam logic [2:0] BIT_LAST = 3'h7;
  // command codes
  localparam logic [7:0] CMD_WRITE_BYTE = 8'ha5;
  localparam logic [7:0] CMD_READ_BYTE = 8'h96;
  // register byte addresses
  localparam logic [4:0] ADDR_CMD = 5'h00;
  localparam logic [4:0] ADDR_STATUS = 5'h04;
  localparam logic [4:0] ADDR_CONFIG = 5'h08;
  localparam logic [4:0] ADDR_READ_DATA = 5'h0c;
  localparam logic [4:0] ADDR_PTR = 5'h10;
  localparam logic [4:0] ADDR_WINDOW = 5'h14;
  // field positions
  localparam int CMD_CODE_LSB = 0;
  localparam int CMD_DATA_LSB = 8;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_REFUSED_BIT = 1;
  localparam int STATUS_SPU_ON_BIT = 2;
  localparam int CFG_SPEED_BIT = 0;
  localparam int CFG_APU_BIT = 1;
  localparam int CFG_SPU_BIT = 2;
  localparam logic [2:0] CFG_RESET = 3'h0;
  // read pointer selections
  localparam logic [1:0] PTR_STATUS = 2'h0;
  localparam logic [1:0] PTR_CONFIG = 2'h1;
  localparam logic [1:0] PTR_READ_DATA = 2'h2;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : swio_pkg

// ===== rtl/swio_slot.sv
// Purpose: one single-wire time slot, write-zero or write-one/read
// Assumes: line_sync_i already synchronised; bit and speed steady per slot
// Notes: done_o is combinational so the next slot follows without a gap
`timescale 1ns/1ps
`default_nettype none
module swio_slot import swio_pkg::*; (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // slot request
  input wire logic start_i,
  input wire logic bit_i,
  input wire logic speed_i,
  input wire logic apu_i,
  input wire logic line_sync_i,
  // slot results
  output logic drive_low_o,
  output logic active_pull_o,
  output logic sample_o,
  output logic sample_bit_o,
  output logic done_o
);
  logic active, bit_q;
  logic [11:0] cnt;
  logic next_active, next_bit_q, next_drive, next_apu, next_sample, next_sample_bit;
  logic [11:0] next_cnt, slot_last, low_len, samp_at;

  always_comb begin
    slot_last = (speed_i ? SLOT_OD_CYC : SLOT_STD_CYC) - CNT_ONE;
    samp_at = speed_i ? SAMP_OD_CYC : SAMP_STD_CYC;
    done_o = active && (cnt == slot_last);
    next_active = active;
    next_cnt = cnt;
    next_bit_q = bit_q;
    if (start_i) begin
      next_active = 1'b1;
      next_cnt = '0;
      next_bit_q = bit_i;
    end else if (active) begin
      if (done_o) begin
        next_active = 1'b0;
      end else begin
        next_cnt = cnt + CNT_ONE;
      end
    end
    if (next_bit_q) begin
      low_len = speed_i ? LOW1_OD_CYC : LOW1_STD_CYC;
    end else begin
      low_len = speed_i ? LOW0_OD_CYC : LOW0_STD_CYC;
    end
    next_drive = next_active && (next_cnt < low_len);
    next_apu = apu_i && next_active && (next_cnt >= low_len) && (next_cnt < low_len + APU_CYC);
    next_sample = active && (cnt == samp_at);
    next_sample_bit = next_sample ? line_sync_i : sample_bit_o;
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      active <= 1'b0;
      cnt <= '0;
      bit_q <= 1'b1;
      drive_low_o <= 1'b0;
      active_pull_o <= 1'b0;
      sample_o <= 1'b0;
      sample_bit_o <= 1'b0;
    end else begin
      active <= next_active;
      cnt <= next_cnt;
      bit_q <= next_bit_q;
      drive_low_o <= next_drive;
      active_pull_o <= next_apu;
      sample_o <= next_sample;
      sample_bit_o <= next_sample_bit;
    end
  end
endmodule : swio_slot
`default_nettype wire

// ===== rtl/single_wire_byte_io.sv
// Purpose: byte write and byte read commands onto a single-wire line
// Assumes: one clock at 40 MHz; commands arrive over AXI4-Lite
// Notes: a refused command answers SLVERR in place of an acknowledge
//
// Added by the designer: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module single_wire_byte_io import swio_pkg::*; (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // axi4-lite write address and data
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [4:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // single-wire line, open drain
  input wire logic line_in_i,
  output logic line_out_o,
  output logic line_oe_n_o,
  // pullup controls and busy
  output logic strong_pullup_o,
  output logic active_pullup_o,
  output logic line_busy_flag_o
);
  ////////////////////////////////////////////////////////////////////////////////
  // line input synchroniser
  logic line_meta, line_sync;
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      line_meta <= 1'b1;
      line_sync <= 1'b1;
    end else begin
      line_meta <= line_in_i;
      line_sync <= line_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // control: write channel and byte engine
  logic aw_hold, w_hold, bvalid, busy, op_read, op_speed, op_apu, start_q;
  logic strong_pu, refused;
  logic [1:0] bresp, ptr;
  logic [2:0] bit_cnt, cfg;
  logic [3:0] wstrb_q;
  logic [4:0] waddr;
  logic [7:0] shift, read_data, code, cmd_data;
  logic [31:0] wdata;
  logic next_aw_hold, next_w_hold, next_bvalid, next_busy, next_op_read, next_op_speed;
  logic next_op_apu, next_start_q, next_strong_pu, next_refused;
  logic [1:0] next_bresp, next_ptr;
  logic [2:0] next_bit_cnt, next_cfg;
  logic [3:0] next_wstrb_q;
  logic [4:0] next_waddr;
  logic [7:0] next_shift, next_read_data;
  logic [31:0] next_wdata;
  logic do_write, cmd_ok;
  logic slot_start, slot_bit, slot_done, slot_sample, slot_sample_bit, slot_drive, slot_apu;

  assign s_axi_awready = !aw_hold && !bvalid;
  assign s_axi_wready = !w_hold && !bvalid;
  assign do_write = aw_hold && w_hold && !bvalid;
  assign code = wdata[CMD_CODE_LSB +: 8];
  assign cmd_data = wdata[CMD_DATA_LSB +: 8];
  assign cmd_ok = do_write && (waddr == ADDR_CMD) && !busy
    && ((code == CMD_WRITE_BYTE) || (code == CMD_READ_BYTE));
  // chain slots back to back; next bit is shift[1] while the old one retires
  assign slot_start = start_q || (slot_done && (bit_cnt != BIT_LAST));
  assign slot_bit = op_read ? 1'b1 : (slot_done ? shift[1] : shift[0]);

  always_comb begin
    next_aw_hold = aw_hold;
    next_w_hold = w_hold;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_waddr = waddr;
    next_wdata = wdata;
    next_wstrb_q = wstrb_q;
    next_busy = busy;
    next_op_read = op_read;
    next_op_speed = op_speed;
    next_op_apu = op_apu;
    next_start_q = 1'b0;
    next_strong_pu = strong_pu;
    next_refused = refused;
    next_ptr = ptr;
    next_bit_cnt = bit_cnt;
    next_cfg = cfg;
    next_shift = shift;
    next_read_data = read_data;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_hold = 1'b1;
      next_waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_hold = 1'b1;
      next_wdata = s_axi_wdata;
      next_wstrb_q = s_axi_wstrb;
    end
    if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (slot_sample && op_read) begin
      next_shift = {slot_sample_bit, shift[7:1]};
    end
    if (slot_done) begin
      next_bit_cnt = bit_cnt + 3'h1;
      if (!op_read) begin
        next_shift = {1'b0, shift[7:1]};
      end
      if (bit_cnt == BIT_LAST) begin
        next_busy = 1'b0;
        if (op_read) begin
          next_read_data = shift;
        end else begin
          next_strong_pu = cfg[CFG_SPU_BIT];
        end
      end
    end
    if (do_write) begin
      next_aw_hold = 1'b0;
      next_w_hold = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      if (waddr == ADDR_CMD) begin
        if (cmd_ok) begin
          next_busy = 1'b1;
          next_start_q = 1'b1;
          next_op_read = (code == CMD_READ_BYTE);
          next_op_speed = cfg[CFG_SPEED_BIT];
          next_op_apu = cfg[CFG_APU_BIT];
          next_bit_cnt = '0;
          next_shift = (code == CMD_WRITE_BYTE) ? cmd_data : '0;
          next_ptr = PTR_STATUS;
          next_strong_pu = 1'b0;
          next_refused = 1'b0;
        end else begin
          next_bresp = RESP_SLVERR;
          if (busy) begin
            next_refused = 1'b1;
          end
        end
      end else if (waddr == ADDR_CONFIG) begin
        if (wstrb_q[0]) begin
          next_cfg = wdata[2:0];
          if (!wdata[CFG_SPU_BIT]) begin
            next_strong_pu = 1'b0;
          end
        end
      end else if (waddr == ADDR_PTR) begin
        if (wstrb_q[0]) begin
          next_ptr = wdata[1:0];
        end
      end else begin
        next_bresp = RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      waddr <= '0;
      wdata <= '0;
      wstrb_q <= '0;
      busy <= 1'b0;
      op_read <= 1'b0;
      op_speed <= 1'b0;
      op_apu <= 1'b0;
      start_q <= 1'b0;
      strong_pu <= 1'b0;
      refused <= 1'b0;
      ptr <= PTR_STATUS;
      bit_cnt <= '0;
      cfg <= CFG_RESET;
      shift <= '0;
      read_data <= '0;
    end else begin
      aw_hold <= next_aw_hold;
      w_hold <= next_w_hold;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      waddr <= next_waddr;
      wdata <= next_wdata;
      wstrb_q <= next_wstrb_q;
      busy <= next_busy;
      op_read <= next_op_read;
      op_speed <= next_op_speed;
      op_apu <= next_op_apu;
      start_q <= next_start_q;
      strong_pu <= next_strong_pu;
      refused <= next_refused;
      ptr <= next_ptr;
      bit_cnt <= next_bit_cnt;
      cfg <= next_cfg;
      shift <= next_shift;
      read_data <= next_read_data;
    end
  end

  swio_slot u_slot (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .start_i(slot_start),
    .bit_i(slot_bit),
    .speed_i(op_speed),
    .apu_i(op_apu),
    .line_sync_i(line_sync),
    .drive_low_o(slot_drive),
    .active_pull_o(slot_apu),
    .sample_o(slot_sample),
    .sample_bit_o(slot_sample_bit),
    .done_o(slot_done)
  );

  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign line_out_o = 1'b0;
  assign line_oe_n_o = !slot_drive;
  assign strong_pullup_o = strong_pu;
  assign active_pullup_o = slot_apu;
  assign line_busy_flag_o = busy;

  ////////////////////////////////////////////////////////////////////////////////
  // read channel
  logic rvalid;
  logic [1:0] rresp, next_rresp;
  logic [31:0] rdata, next_rdata, status_word, config_word, rdd_word, view_word;
  logic next_rvalid;

  assign s_axi_arready = !rvalid;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;

  always_comb begin
    status_word = '0;
    status_word[STATUS_BUSY_BIT] = busy;
    status_word[STATUS_REFUSED_BIT] = refused;
    status_word[STATUS_SPU_ON_BIT] = strong_pu;
    config_word = {29'h0, cfg};
    rdd_word = {24'h0, read_data};
    if (ptr == PTR_STATUS) begin
      view_word = status_word;
    end else if (ptr == PTR_CONFIG) begin
      view_word = config_word;
    end else if (ptr == PTR_READ_DATA) begin
      view_word = rdd_word;
    end else begin
      view_word = '0;
    end
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      if (s_axi_araddr == ADDR_STATUS) begin
        next_rdata = status_word;
      end else if (s_axi_araddr == ADDR_CONFIG) begin
        next_rdata = config_word;
      end else if (s_axi_araddr == ADDR_READ_DATA) begin
        next_rdata = rdd_word;
      end else if (s_axi_araddr == ADDR_PTR) begin
        next_rdata = {30'h0, ptr};
      end else if (s_axi_araddr == ADDR_WINDOW) begin
        next_rdata = view_word;
      end else begin
        next_rdata = '0;
        next_rresp = RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else begin
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  logic [15:0] busy_cyc, busy_expect;
  always_ff @(posedge clock_i) begin
    if (rst_i || !busy) begin
      busy_cyc <= '0;
    end else begin
      busy_cyc <= busy_cyc + 16'h0001;
    end
  end
  assign busy_expect = SLOTS_PER_BYTE * {4'h0, op_speed ? SLOT_OD_CYC : SLOT_STD_CYC}
    + 16'h0001;

  chk_busy_length: assert property (@(posedge clock_i) disable iff (rst_i)
    $fell(busy) |-> busy_cyc == busy_expect)
    else $error("busy held for wrong number of cycles");
  chk_busy_refuse: assert property (@(posedge clock_i) disable iff (rst_i)
    (do_write && waddr == ADDR_CMD && busy) |=> (bvalid && bresp == RESP_SLVERR
      && !start_q && $stable(op_read)))
    else $error("command taken while busy");
  chk_start_line: assert property (@(posedge clock_i) disable iff (rst_i)
    $rose(busy) |-> ##[1:10] !line_oe_n_o)
    else $error("line activity started late");
  chk_read_ones: assert property (@(posedge clock_i) disable iff (rst_i)
    (slot_start && op_read && !start_q) or (start_q && op_read) |-> slot_bit)
    else $error("read slot not a write-one slot");
  chk_write_lsb: assert property (@(posedge clock_i) disable iff (rst_i)
    (cmd_ok && code == CMD_WRITE_BYTE) |=> slot_bit == $past(wdata[CMD_DATA_LSB]))
    else $error("write byte did not begin with bit 0");
  chk_read_order: assert property (@(posedge clock_i) disable iff (rst_i)
    (slot_sample && op_read) |=> shift[7] == $past(slot_sample_bit))
    else $error("read bit not shifted in from the top");
  chk_ptr_status: assert property (@(posedge clock_i) disable iff (rst_i)
    $rose(busy) |-> ptr == PTR_STATUS)
    else $error("pointer not on status after command");
  chk_read_store: assert property (@(posedge clock_i) disable iff (rst_i)
    ($fell(busy) && op_read) |-> read_data == $past(shift))
    else $error("read data not stored at end of read byte");
  chk_spu_write: assert property (@(posedge clock_i) disable iff (rst_i)
    $rose(strong_pu) |-> !op_read && cfg[CFG_SPU_BIT] && $fell(busy))
    else $error("strong pullup outside a write byte");
endmodule : single_wire_byte_io
`default_nettype wire

// ===== verif/swio_slave_model.sv
// Purpose: far-side line device answering byte write and read slots
// Assumes: line level has a pull-up; slots start on a falling line edge
// Notes: pull is held past the master sample point, released before slot end
`timescale 1ns/1ps
`default_nettype none
module swio_slave_model (
  // line, speed and mode
  input wire logic line_i,
  input wire logic od_i,
  input wire logic reading_i,
  input wire logic [7:0] tx_i,
  // pull and byte seen
  output logic pull_o,
  output logic [7:0] rx_o
);
  int idx;
  initial begin
    pull_o = 1'b0;
    rx_o = 8'h00;
    idx = 0;
    forever begin
      @(negedge line_i);
      pull_o = reading_i && !tx_i[idx];
      #(od_i ? 2510 : 30010);
      rx_o[idx] = line_i;
      pull_o = 1'b0;
      idx = (idx + 1) % 8;
    end
  end
endmodule : swio_slave_model
`default_nettype wire

// ===== verif/single_wire_byte_io_tb_top.sv
// Purpose: self-checking bench for byte write and byte read commands
// Assumes: registers reached over axi4-lite, open-drain line with pull-up
// Notes: expected read bytes kept in a queue, slot timing from the package
`timescale 1ns/1ps
`default_nettype none
module single_wire_byte_io_tb_top import swio_pkg::*;;
  logic clock_i, rst_i;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [4:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic line_out_o, line_oe_n_o, strong_pullup_o, active_pullup_o, line_busy_flag_o;
  logic od, reading, slave_pull, apu_q;
  logic [7:0] slave_tx, slave_rx;
  logic [7:0] exp_q[$];
  int busy_cyc, low_cyc, max_low, first_oe, apu_rises, miscompares, compares;
  integer seed = 32'h084c;
  wire line = (line_oe_n_o === 1'b0) ? (line_out_o && !slave_pull) : !slave_pull;

  single_wire_byte_io u_single_wire_byte_io (
    .clock_i(clock_i), .rst_i(rst_i),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .line_in_i(line), .line_out_o(line_out_o), .line_oe_n_o(line_oe_n_o),
    .strong_pullup_o(strong_pullup_o), .active_pullup_o(active_pullup_o),
    .line_busy_flag_o(line_busy_flag_o)
  );
  swio_slave_model u_swio_slave_model (
    .line_i(line), .od_i(od), .reading_i(reading), .tx_i(slave_tx),
    .pull_o(slave_pull), .rx_o(slave_rx)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // line monitor: busy span, low pulse length, start delay, pullup pulses
  always @(posedge clock_i) begin
    apu_q <= active_pullup_o;
    if (active_pullup_o === 1'b1 && apu_q === 1'b0) apu_rises <= apu_rises + 1;
    if (line_busy_flag_o === 1'b1) busy_cyc <= busy_cyc + 1;
    if (line_oe_n_o === 1'b0) low_cyc <= low_cyc + 1;
    else if (low_cyc != 0) begin
      max_low <= (low_cyc > max_low) ? low_cyc : max_low;
      low_cyc <= 0;
    end
    if (line_busy_flag_o === 1'b1 && line_oe_n_o === 1'b0 && first_oe < 0) first_oe <= busy_cyc;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clock_i);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_bready <= 1'b1;
    while (n < 100) begin
      @(posedge clock_i);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        r = s_axi_bresp;
        n = 1000;
      end
    end
    s_axi_bready <= 1'b0;
    if (n < 1000) check(32'h0, 32'h1);
  endtask : axi_wr

  task automatic axi_rd(input logic [4:0] a, output logic [31:0] v, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clock_i);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    while (n < 100) begin
      @(posedge clock_i);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        v = s_axi_rdata;
        r = s_axi_rresp;
        n = 1000;
      end
    end
    s_axi_rready <= 1'b0;
    if (n < 1000) check(32'h0, 32'h1);
  endtask : axi_rd

  task automatic byte_cmd(input logic [7:0] code, input logic [7:0] d, input logic [2:0] cfg);
    logic [1:0] r;
    logic [31:0] v;
    int slot, n, low0, low1;
    logic rd;
    rd = (code == CMD_READ_BYTE);
    slot = cfg[CFG_SPEED_BIT] ? int'(SLOT_OD_CYC) : int'(SLOT_STD_CYC);
    low0 = cfg[CFG_SPEED_BIT] ? int'(LOW0_OD_CYC) : int'(LOW0_STD_CYC);
    low1 = cfg[CFG_SPEED_BIT] ? int'(LOW1_OD_CYC) : int'(LOW1_STD_CYC);
    axi_wr(ADDR_CONFIG, {29'h0, cfg}, r);
    od = cfg[CFG_SPEED_BIT];
    reading = rd;
    slave_tx = d;
    if (rd) exp_q.push_back(d);
    busy_cyc = 0;
    first_oe = -1;
    max_low = 0;
    apu_rises = 0;
    axi_wr(ADDR_CMD, {16'h0, d, code}, r);
    check(32'(r), 32'(RESP_OKAY));
    axi_wr(ADDR_CMD, {16'h0, d, code}, r);
    check(32'(r), 32'(RESP_SLVERR));
    axi_rd(ADDR_STATUS, v, r);
    check(v & 32'h3, 32'h3);
    n = 0;
    while (line_busy_flag_o !== 1'b0 && n < 30000) begin
      @(posedge clock_i);
      n++;
    end
    repeat (4) @(posedge clock_i);
    check(32'(busy_cyc), 32'(1 + 8 * slot));
    check(32'(busy_cyc <= 8 * slot + START_MAX_CYC), 32'h1);
    check(32'(first_oe >= 0 && first_oe <= START_MAX_CYC), 32'h1);
    check(32'(apu_rises), cfg[CFG_APU_BIT] ? 32'h8 : 32'h0);
    check(32'(strong_pullup_o), 32'(cfg[CFG_SPU_BIT] && !rd));
    if (!rd) begin
      check(32'(slave_rx), 32'(d));
      check(32'(max_low), 32'((d == 8'hff) ? low1 : low0));
    end else begin
      check(32'(max_low), 32'(low1));
      axi_rd(ADDR_WINDOW, v, r);
      check(v & 32'hffff_fffd, 32'h0);
      axi_wr(ADDR_PTR, 32'(PTR_READ_DATA), r);
      axi_rd(ADDR_WINDOW, v, r);
      check(v, 32'(exp_q.pop_front()));
    end
  endtask : byte_cmd

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = !clock_i;
  end

  initial begin
    #(25 * 70000);
    miscompares++;
    wrap_up();
  end

  initial begin
    logic [1:0] r;
    logic [31:0] v;
    rst_i = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 5'h00;
    s_axi_araddr = 5'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    {od, reading, slave_tx} = 10'h000;
    {busy_cyc, low_cyc, max_low, apu_rises, miscompares, compares} = '0;
    first_oe = -1;
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    check(32'({line_busy_flag_o, line_oe_n_o, strong_pullup_o}), 32'h2);
    axi_rd(ADDR_STATUS, v, r);
    check(v, 32'h0);
    axi_rd(ADDR_CONFIG, v, r);
    check(v, 32'(CFG_RESET));
    axi_rd(5'h1c, v, r);
    check(32'(r), 32'(RESP_SLVERR));
    axi_wr(ADDR_STATUS, 32'h1, r);
    check(32'(r), 32'(RESP_SLVERR));
    axi_wr(ADDR_CMD, 32'h0000_3c11, r);
    check(32'(r), 32'(RESP_SLVERR));
    check(32'(line_busy_flag_o), 32'h0);
    byte_cmd(CMD_WRITE_BYTE, 8'($random(seed)), 3'h7);
    byte_cmd(CMD_READ_BYTE, 8'($random(seed)), 3'h7);
    byte_cmd(CMD_WRITE_BYTE, 8'hff, 3'h3);
    byte_cmd(CMD_READ_BYTE, 8'($random(seed)), 3'h0);
    wrap_up();
  end
endmodule : single_wire_byte_io_tb_top
`default_nettype wire
